/* File: hw/swc_map.svh */
// Register map and constants of the stopwatch capture control block
`ifndef SWC_MAP_SVH
`define SWC_MAP_SVH

// Register indices; byte address is four times the index
`define SWC_IDX_KEYPORT   18'h0_ff06
`define SWC_IDX_DIRCTL    18'h0_ff78
`define SWC_IDX_CTLFLAGS  18'h0_ff79
`define SWC_IDX_DIG_THOU  18'h0_ff7a
`define SWC_IDX_DIG_HUND  18'h0_ff7b
`define SWC_IDX_DIG_TENTH 18'h0_ff7c
`define SWC_IDX_IRQ_EN    18'h0_ffe6
`define SWC_IDX_IRQ_PEND  18'h0_fff6

// Field positions
`define SWC_BIT_SWAP      2
`define SWC_BIT_DIR_EN    3
`define SWC_BIT_CLEAR     0
`define SWC_BIT_RUN       1
`define SWC_BIT_RENEWED   2
`define SWC_BIT_CARRY     3

// Reset values
`define SWC_RST_NIB       4'h0
`define SWC_RST_DIG       12'h000

// Timing
`define SWC_PCLK_HZ       125000000
`define SWC_TICK_HZ       1024

`endif

/* File: hw/swc_pkg.sv */
// Types shared by the stopwatch capture control block
package swc_pkg;

  // Interrupt sources, bit order of enable and pending registers
  typedef struct packed {
    logic run_key;
    logic lap_key;
    logic one_hz;
    logic ten_hz;
  } swc_irq_s;

  // Key port inputs: port1 bits 3..0, port0 bits 3..0
  typedef struct packed {
    logic [3:0] port1;
    logic [3:0] port0;
  } swc_keys_s;

  // Three BCD digits of the stopwatch
  typedef struct packed {
    logic [3:0] tenths;
    logic [3:0] hundredths;
    logic [3:0] thousandths;
  } swc_digits_s;

  // Hold state of the capture buffer
  typedef enum logic [0:0] {
    SWC_TRACK,
    SWC_HOLD
  } swc_hold_e;

endpackage : swc_pkg

/* File: hw/swc_top.sv */
// Stopwatch capture control: APB registers, keys, capture, flags
`timescale 1ns/10ps
`include "swc_map.svh"

module swc_top #(
  parameter int ADDR_W   = 18,
  parameter int TICK_DIV = `SWC_PCLK_HZ / `SWC_TICK_HZ
) (
  // Clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Counting chain
  input  wire swc_pkg::swc_digits_s live_count,
  input  wire logic                one_hz_evt,
  input  wire logic                ten_hz_evt,
  output logic                     stopwatch_run,
  output logic                     stopwatch_clear,
  // Key pins, asynchronous
  input  wire swc_pkg::swc_keys_s  key_pins,
  // Interrupt requests
  output swc_pkg::swc_irq_s        irq_req
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (ADDR_W < 18) begin : g_addr_chk
    $error("swc_top: ADDR_W must hold the highest register");
  end
  if (TICK_DIV < 2) begin : g_tick_chk
    $error("swc_top: TICK_DIV must be at least 2");
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [17:0] idx);
    hit = (a[1:0] == 2'b00) && (a[ADDR_W-1:2] == (ADDR_W-2)'(idx));
  endfunction

  function automatic logic [31:0] nib(input logic [3:0] v);
    nib = {28'h000_0000, v};
  endfunction

  logic setup_rd, done, done_wr, mapped;
  assign setup_rd = psel && !penable && !pwrite;
  assign done     = psel && penable && pready;
  assign done_wr  = done && pwrite;

  logic h_key, h_dir, h_ctl, h_thou, h_hund, h_tenth, h_ien, h_ipd;
  assign h_key   = hit(paddr, `SWC_IDX_KEYPORT);
  assign h_dir   = hit(paddr, `SWC_IDX_DIRCTL);
  assign h_ctl   = hit(paddr, `SWC_IDX_CTLFLAGS);
  assign h_thou  = hit(paddr, `SWC_IDX_DIG_THOU);
  assign h_hund  = hit(paddr, `SWC_IDX_DIG_HUND);
  assign h_tenth = hit(paddr, `SWC_IDX_DIG_TENTH);
  assign h_ien   = hit(paddr, `SWC_IDX_IRQ_EN);
  assign h_ipd   = hit(paddr, `SWC_IDX_IRQ_PEND);
  assign mapped  = h_key | h_dir | h_ctl | h_thou | h_hund
                 | h_tenth | h_ien | h_ipd;

  // Read side effects fire once, in the setup cycle
  logic rd_thou, rd_tenth;
  assign rd_thou  = setup_rd && h_thou;
  assign rd_tenth = setup_rd && h_tenth;

  // ----------------------------------------------------------------
  // Key synchronisers
  // ----------------------------------------------------------------
  logic [7:0] key_meta_q, key_sync_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_meta_q <= 8'h00;
      key_sync_q <= 8'h00;
    end else begin
      key_meta_q <= key_pins;
      key_sync_q <= key_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // 1,024 Hz falling edge tick
  // ----------------------------------------------------------------
  logic [31:0] tick_cnt_q;
  logic        tick;
  assign tick = (tick_cnt_q == 32'(TICK_DIV - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= 32'h0000_0000;
    end else if (tick) begin
      tick_cnt_q <= 32'h0000_0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic       swap_q, dir_en_q, dir_eff_q;
  logic [2:0] kmask_q;
  swc_pkg::swc_irq_s ien_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swap_q <= 1'b0;
    end else if (done_wr && h_key) begin
      swap_q <= pwdata[`SWC_BIT_SWAP];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_en_q <= 1'b0;
      kmask_q  <= 3'b000;
    end else if (done_wr && h_dir) begin
      dir_en_q <= pwdata[`SWC_BIT_DIR_EN];
      kmask_q  <= pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_eff_q <= 1'b0;
    end else if (tick) begin
      dir_eff_q <= dir_en_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_q <= '0;
    end else if (done_wr && h_ien) begin
      ien_q <= pwdata[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Direct key decode
  // ----------------------------------------------------------------
  logic [5:0] mask_keys, other_keys;
  logic       blocked, run_key, lap_key;
  logic       run_key_q, lap_key_q, run_press, lap_press;

  // mask selection: port0 bits 2,3 then port1 bits 0..3
  always_comb begin
    case (kmask_q)
      3'd1:    mask_keys = 6'h01;
      3'd2:    mask_keys = 6'h03;
      3'd3:    mask_keys = 6'h07;
      3'd4:    mask_keys = 6'h04;
      3'd5:    mask_keys = 6'h0c;
      3'd6:    mask_keys = 6'h1c;
      3'd7:    mask_keys = 6'h3c;
      default: mask_keys = 6'h00;
    endcase
  end

  // Candidate mask keys, one bit each: port1 bits 3..0, port0 bits 3..2
  assign other_keys = key_sync_q[7:2];

  assign run_key = swap_q ? key_sync_q[1] : key_sync_q[0];
  assign lap_key = swap_q ? key_sync_q[0] : key_sync_q[1];

  assign blocked = |(mask_keys & other_keys) & (run_key | lap_key);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_key_q <= 1'b0;
      lap_key_q <= 1'b0;
    end else begin
      run_key_q <= run_key;
      lap_key_q <= lap_key;
    end
  end

  // keys act only with direct input in effect
  assign run_press = dir_eff_q && !blocked && run_key && !run_key_q;
  assign lap_press = dir_eff_q && !blocked && lap_key && !lap_key_q;

  // ----------------------------------------------------------------
  // Run state and clear
  // ----------------------------------------------------------------
  logic run_q, clear_q, sw_run_wr;
  // software run only without direct input
  assign sw_run_wr = done_wr && h_ctl && !dir_eff_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b0;
    end else if (run_press) begin
      run_q <= !run_q;
    end else if (sw_run_wr) begin
      run_q <= pwdata[`SWC_BIT_RUN];
    end
  end

  // one-cycle clear to the counting chain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clear_q <= 1'b0;
    end else begin
      clear_q <= done_wr && h_ctl && pwdata[`SWC_BIT_CLEAR];
    end
  end

  // ----------------------------------------------------------------
  // Pending flags
  // ----------------------------------------------------------------
  swc_pkg::swc_irq_s ipd_q, ipd_set, ipd_clr;
  assign ipd_set = '{run_key: run_press, lap_key: lap_press,
                     one_hz: one_hz_evt, ten_hz: ten_hz_evt};
  assign ipd_clr = (done_wr && h_ipd) ? pwdata[3:0] : 4'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ipd_q <= '0;
    end else begin
      ipd_q <= (ipd_q & ~ipd_clr) | ipd_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req <= '0;
    end else begin
      irq_req <= ipd_q & ien_q;
    end
  end

  // ----------------------------------------------------------------
  // Capture buffer
  // ----------------------------------------------------------------
  swc_pkg::swc_hold_e   hold_q;
  swc_pkg::swc_digits_s cap_q;
  logic                 unread_q, renew_q, renewed_flag_q;
  logic                 carry_q, enter_hold;
  assign enter_hold = lap_press || (rd_thou && hold_q == swc_pkg::SWC_TRACK);

  // clear does not touch the buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_q <= `SWC_RST_DIG;
    end else if (lap_press || hold_q == swc_pkg::SWC_TRACK) begin
      cap_q <= live_count;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= swc_pkg::SWC_TRACK;
    end else begin
      case (hold_q)
        swc_pkg::SWC_TRACK: begin
          if (enter_hold) begin
            hold_q <= swc_pkg::SWC_HOLD;
          end
        end
        swc_pkg::SWC_HOLD: begin
          if (rd_tenth && !renew_q && !lap_press) begin
            hold_q <= swc_pkg::SWC_TRACK;
          end
        end
        default: hold_q <= swc_pkg::SWC_TRACK;
      endcase
    end
  end

  // Lap data waiting for its tenths read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unread_q <= 1'b0;
    end else if (lap_press) begin
      unread_q <= 1'b1;
    end else if (rd_tenth) begin
      unread_q <= 1'b0;
    end
  end

  // lap over unread data marks renewal
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      renew_q <= 1'b0;
    end else if (lap_press && unread_q) begin
      renew_q <= 1'b1;
    end else if (rd_tenth) begin
      renew_q <= 1'b0;
    end
  end

  // flag updated by every tenths read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      renewed_flag_q <= 1'b0;
    end else if (rd_tenth) begin
      renewed_flag_q <= renew_q;
    end
  end

  // carry flag sampled on entering hold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carry_q <= 1'b0;
    end else if (enter_hold) begin
      carry_q <= ipd_q.one_hz;
    end
  end

  // ----------------------------------------------------------------
  // APB answer: ready one cycle after setup, no wait in access
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  swc_pkg::swc_digits_s rd_dig;
  // A thousandths read in tracking shows the value it freezes
  assign rd_dig = (hold_q == swc_pkg::SWC_TRACK) ? live_count : cap_q;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (h_key) begin
      rd_mux = nib({1'b0, swap_q, 2'b00});
    end else if (h_dir) begin
      rd_mux = nib({dir_en_q, kmask_q});
    end else if (h_ctl) begin
      // actual run state; clear reads 0
      rd_mux = nib({carry_q, renewed_flag_q, run_q, 1'b0});
    end else if (h_thou) begin
      rd_mux = nib(rd_dig.thousandths);
    end else if (h_hund) begin
      rd_mux = nib(cap_q.hundredths);
    end else if (h_tenth) begin
      rd_mux = nib(cap_q.tenths);
    end else if (h_ien) begin
      rd_mux = nib(ien_q);
    end else if (h_ipd) begin
      rd_mux = nib(ipd_q);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel && !penable) begin
      pready  <= 1'b1;
      pslverr <= !mapped;
      prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs to the counting chain
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stopwatch_run <= 1'b0;
    end else begin
      stopwatch_run <= run_q;
    end
  end

  assign stopwatch_clear = clear_q;

endmodule // swc_top

/* File: tb/swc_key_switches.sv */
// Key switch model on the two key ports
`timescale 1ns/10ps

module swc_key_switches (
  // Clock the switches are moved against
  input  wire logic         pclk,
  // Switch contacts, active high
  output swc_pkg::swc_keys_s key_pins
);
  // Open contacts are pulled low, so a released key reads 0
  logic [7:0] level_q = 8'h00;

  assign key_pins = level_q;

  task automatic hold(input int b, input logic v);
    @(posedge pclk);
    level_q[b] <= v;
  endtask

  // Long enough to pass the synchroniser and the edge detect
  task automatic press(input int b);
    hold(b, 1'b1);
    repeat (6) @(posedge pclk);
    level_q[b] <= 1'b0;
  endtask
endmodule // swc_key_switches

/* File: tb/swc_top_asserts.sv */
// Port checker of the stopwatch capture control
`timescale 1ns/10ps
`include "swc_map.svh"

module swc_top_asserts #(
  parameter int ADDR_W = 18
) (
  // Clock, reset and bus
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Stopwatch outputs
  input wire logic              stopwatch_run,
  input wire logic              stopwatch_clear,
  input wire swc_pkg::swc_irq_s irq_req
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic setup;
  logic wr_end;
  logic mapped;
  logic at_ctl;
  logic at_en;
  assign setup = psel && !penable;
  assign wr_end = psel && penable && pready && pwrite;
  assign at_ctl = (paddr >> 2) == `SWC_IDX_CTLFLAGS;
  assign at_en = (paddr >> 2) == `SWC_IDX_IRQ_EN;
  assign mapped = paddr[1:0] == 2'b00 && ((paddr >> 2) inside {
    `SWC_IDX_KEYPORT, `SWC_IDX_DIRCTL, `SWC_IDX_CTLFLAGS, `SWC_IDX_DIG_THOU,
    `SWC_IDX_DIG_HUND, `SWC_IDX_DIG_TENTH, `SWC_IDX_IRQ_EN,
    `SWC_IDX_IRQ_PEND});
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  ready_answer_a: assert property (setup |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  rdata_upper_a: assert property (pready |-> prdata[31:4] == 28'h000_0000)
    else $error("read data upper bits set");
  unmapped_err_a: assert property (setup && !mapped |=> pslverr)
    else $error("unmapped access without error");
  mapped_ok_a: assert property (setup && mapped |=> !pslverr)
    else $error("mapped access with error");
  clear_pulse_a: assert property (wr_end && at_ctl && pwdata[0]
    |=> stopwatch_clear ##1 !stopwatch_clear)
    else $error("clear pulse missing");
  clear_cause_a: assert property ($rose(stopwatch_clear)
    |-> $past(wr_end && at_ctl && pwdata[0]))
    else $error("clear pulse without write");
  clear_reads_a: assert property (setup && !pwrite && at_ctl
    |=> prdata[0] == 1'b0)
    else $error("clear bit reads one");
  run_read_a: assert property (setup && !pwrite && at_ctl
    |=> prdata[1] == stopwatch_run)
    else $error("run bit differs from run state");
  irq_off_a: assert property (wr_end && at_en && pwdata[3:0] == 4'h0
    |-> ##2 irq_req == '0)
    else $error("request with all sources masked");
  cover property (wr_end && at_ctl && pwdata[0]);
  cover property (pready && pslverr);
  cover property (irq_req != '0);
endmodule // swc_top_asserts

bind swc_top swc_top_asserts #(
  .ADDR_W(ADDR_W)
) u_swc_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .stopwatch_run(stopwatch_run),
  .stopwatch_clear(stopwatch_clear), .irq_req(irq_req)
);

/* File: tb/testbench.sv */
// Self-checking bench of the stopwatch capture control
`timescale 1ns/10ps
`include "swc_map.svh"

module testbench;
  // Short tick keeps the direct enable wait small
  localparam int TD = 20;
  logic                 pclk = 1'b0;
  logic                 presetn = 1'b0;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic [17:0]          paddr;
  logic [31:0]          pwdata;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  swc_pkg::swc_digits_s live;
  logic                 one_hz;
  logic                 ten_hz;
  logic                 sw_run;
  logic                 sw_clr;
  int                   n_clr = 0;
  swc_pkg::swc_keys_s   keys;
  swc_pkg::swc_irq_s    irq;
  logic [31:0]          rdat;
  logic                 serr;
  int                   err_count = 0;
  int                   n_tests = 0;
  logic [17:0]          regs [8] = '{`SWC_IDX_KEYPORT, `SWC_IDX_DIRCTL,
    `SWC_IDX_CTLFLAGS, `SWC_IDX_DIG_THOU, `SWC_IDX_DIG_HUND,
    `SWC_IDX_DIG_TENTH, `SWC_IDX_IRQ_EN, `SWC_IDX_IRQ_PEND};
  int                   kb [7] = '{2, 3, 4, 4, 5, 6, 7};

  swc_top #(.TICK_DIV(TD)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .live_count(live),
    .one_hz_evt(one_hz), .ten_hz_evt(ten_hz), .stopwatch_run(sw_run),
    .stopwatch_clear(sw_clr), .key_pins(keys), .irq_req(irq)
  );
  swc_key_switches kp (.pclk(pclk), .key_pins(keys));

  // Clear pulses seen by the counting chain
  always @(posedge pclk) begin
    if (sw_clr === 1'b1) begin
      n_clr <= n_clr + 1;
    end
  end

  initial begin
    forever #4 pclk = ~pclk;
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic w, input logic [17:0] idx,
                     input logic [3:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= idx << 2;
    pwdata <= {28'h000_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    serr = pslverr;
    if (n >= 50) begin
      err_count++;
      final_report();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [17:0] idx, input logic [3:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rd(input logic [17:0] idx, input logic [3:0] e,
                    input string nm);
    apb(1'b0, idx, 4'h0);
    chk(nm, {28'h000_0000, e}, rdat);
  endtask

  initial begin
    cyc(100000);
    err_count++;
    final_report();
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 18'h0_0000;
    pwdata <= 32'h0000_0000;
    live <= 12'h000;
    one_hz <= 1'b0;
    ten_hz <= 1'b0;
    cyc(20);
    presetn <= 1'b1;
    cyc(1);
    foreach (regs[i]) rd(regs[i], 4'h0, "reset value");
    rd(18'h0_1000, 4'h0, "unmapped read");
    chk("unmapped error", 32'h0000_0001, {31'h0000_0000, serr});
    $display("test reset done");
    live <= 12'h987;
    cyc(2);
    rd(`SWC_IDX_DIG_THOU, 4'h7, "thousandths");
    live <= 12'h123;
    rd(`SWC_IDX_DIG_HUND, 4'h8, "held hundredths");
    wr(`SWC_IDX_CTLFLAGS, 4'h1);
    wr(`SWC_IDX_IRQ_PEND, 4'hf);
    rd(`SWC_IDX_DIG_TENTH, 4'h9, "held tenths");
    chk("clear pulses", 32'h0000_0001, n_clr);
    wr(`SWC_IDX_DIG_THOU, 4'hf);
    rd(`SWC_IDX_DIG_THOU, 4'h3, "thousandths after write");
    rd(`SWC_IDX_DIG_HUND, 4'h2, "hundredths");
    rd(`SWC_IDX_DIG_TENTH, 4'h1, "tenths");
    $display("test capture done");
    wr(`SWC_IDX_CTLFLAGS, 4'h2);
    rd(`SWC_IDX_CTLFLAGS, 4'h2, "run bit");
    chk("run output", 32'h0000_0001, {31'h0000_0000, sw_run});
    wr(`SWC_IDX_CTLFLAGS, 4'h0);
    rd(`SWC_IDX_CTLFLAGS, 4'h0, "stop bit");
    $display("test run done");
    one_hz <= 1'b1;
    ten_hz <= 1'b1;
    cyc(1);
    one_hz <= 1'b0;
    ten_hz <= 1'b0;
    cyc(2);
    rd(`SWC_IDX_IRQ_PEND, 4'h3, "masked pending");
    chk("masked request", 32'h0000_0000, {28'h000_0000, irq});
    wr(`SWC_IDX_IRQ_EN, 4'h2);
    cyc(2);
    chk("one hz request", 32'h0000_0002, {28'h000_0000, irq});
    wr(`SWC_IDX_IRQ_PEND, 4'h0);
    rd(`SWC_IDX_IRQ_PEND, 4'h3, "pending after 0");
    wr(`SWC_IDX_IRQ_PEND, 4'h1);
    rd(`SWC_IDX_IRQ_PEND, 4'h2, "pending after 1");
    $display("test interrupt done");
    wr(`SWC_IDX_DIRCTL, 4'h8);
    cyc(2 * TD + 4);
    rd(`SWC_IDX_DIRCTL, 4'h8, "direct enable");
    wr(`SWC_IDX_CTLFLAGS, 4'h2);
    rd(`SWC_IDX_CTLFLAGS, 4'h0, "software run ignored");
    kp.press(0);
    cyc(8);
    rd(`SWC_IDX_CTLFLAGS, 4'h2, "key run");
    rd(`SWC_IDX_IRQ_PEND, 4'ha, "run pending");
    live <= 12'h456;
    kp.press(1);
    cyc(8);
    live <= 12'h000;
    rd(`SWC_IDX_CTLFLAGS, 4'ha, "carry flag");
    rd(`SWC_IDX_DIG_THOU, 4'h6, "lap thousandths");
    rd(`SWC_IDX_DIG_HUND, 4'h5, "lap hundredths");
    rd(`SWC_IDX_DIG_TENTH, 4'h4, "lap tenths");
    live <= 12'h111;
    kp.press(1);
    cyc(8);
    live <= 12'h222;
    kp.press(1);
    cyc(8);
    rd(`SWC_IDX_DIG_THOU, 4'h2, "renewed thousandths");
    rd(`SWC_IDX_DIG_HUND, 4'h2, "renewed hundredths");
    rd(`SWC_IDX_DIG_TENTH, 4'h2, "renewed tenths");
    rd(`SWC_IDX_CTLFLAGS, 4'he, "renewed flag");
    rd(`SWC_IDX_DIG_TENTH, 4'h2, "second tenths");
    rd(`SWC_IDX_CTLFLAGS, 4'ha, "renewed cleared");
    $display("test direct keys done");
    wr(`SWC_IDX_IRQ_PEND, 4'hf);
    for (int m = 1; m < 8; m++) begin
      wr(`SWC_IDX_DIRCTL, 4'(8 + m));
      kp.hold(kb[m-1], 1'b1);
      kp.press(0);
      cyc(8);
      kp.hold(kb[m-1], 1'b0);
      rd(`SWC_IDX_IRQ_PEND, 4'h0, "blocked key");
    end
    chk("run kept", 32'h0000_0001, {31'h0000_0000, sw_run});
    wr(`SWC_IDX_DIRCTL, 4'he);
    kp.hold(7, 1'b1);
    kp.press(0);
    cyc(8);
    kp.hold(7, 1'b0);
    rd(`SWC_IDX_IRQ_PEND, 4'h8, "unselected key");
    chk("run freed", 32'h0000_0000, {31'h0000_0000, sw_run});
    wr(`SWC_IDX_IRQ_PEND, 4'hf);
    $display("test key mask done");
    wr(`SWC_IDX_DIRCTL, 4'h8);
    wr(`SWC_IDX_KEYPORT, 4'h4);
    rd(`SWC_IDX_KEYPORT, 4'h4, "swap bit");
    kp.press(0);
    cyc(8);
    rd(`SWC_IDX_IRQ_PEND, 4'h4, "swapped lap");
    kp.press(1);
    cyc(8);
    rd(`SWC_IDX_IRQ_PEND, 4'hc, "swapped run");
    chk("run toggled", 32'h0000_0001, {31'h0000_0000, sw_run});
    wr(`SWC_IDX_IRQ_EN, 4'hc);
    cyc(2);
    chk("key requests", 32'h0000_000c, {28'h000_0000, irq});
    wr(`SWC_IDX_IRQ_EN, 4'h0);
    cyc(3);
    chk("masked again", 32'h0000_0000, {28'h000_0000, irq});
    $display("test swap done");
    final_report();
  end
endmodule // testbench
